// ---- cssc_pkg.sv ----
package cssc_pkg;
  // Register byte offsets on APB
  localparam logic [11:0] CSSC_OFF_TRIM   = 12'h000;
  localparam logic [11:0] CSSC_OFF_PCTRL  = 12'h004;
  localparam logic [11:0] CSSC_OFF_STATUS = 12'h008;
  // Reset values
  localparam logic [7:0]  CSSC_PCTRL_RST  = 8'h00;
  // Field positions in power_control
  localparam int          CSSC_ARM_BIT    = 6;
  localparam int          CSSC_KIND_HI    = 7;
  localparam int          CSSC_KIND_MID   = 5;
  localparam int          CSSC_KIND_LO    = 4;
  // Clock origin codes
  localparam logic [3:0]  CSSC_ORIGIN_EXT = 4'h0;
  localparam logic [3:0]  CSSC_ORIGIN_RCLO = 4'h1;
  localparam logic [3:0]  CSSC_ORIGIN_RCHI = 4'h4;
  localparam logic [3:0]  CSSC_ORIGIN_XTAL = 4'hA;
  // Timing
  localparam int          CSSC_CLK_MHZ    = 250;
  localparam int          CSSC_START_CK   = 6;
  localparam int          CSSC_WAKE_HALT  = 4;
  localparam int          CSSC_LOAD_LAG   = 2;
  localparam int          CSSC_STBY_CK    = 6;
  localparam int          CSSC_DLY1_US    = 4100;
  localparam int          CSSC_DLY2_US    = 65000;
  localparam int          CSSC_DLY1_CYC   = CSSC_DLY1_US * CSSC_CLK_MHZ;
  localparam int          CSSC_DLY2_CYC   = CSSC_DLY2_US * CSSC_CLK_MHZ;

  typedef enum logic [2:0] {
    KIND_IDLE   = 3'h0,
    KIND_NOISE  = 3'h1,
    KIND_PDOWN  = 3'h2,
    KIND_PSAVE  = 3'h3,
    KIND_RES4   = 3'h4,
    KIND_RES5   = 3'h5,
    KIND_STBY   = 3'h6,
    KIND_XSTBY  = 3'h7
  } cssc_kind_t;

  typedef enum {
    ST_RESET,
    ST_RUN,
    ST_SLEEP,
    ST_START,
    ST_HALT
  } cssc_state_t;

  // Clock gate enables toward the clock tree
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic mainOsc;
  } cssc_gates_t;
endpackage

// ---- cssc_delay_counter.sv ----
`timescale 1ns/1ns
module cssc_delay_counter
  import cssc_pkg::*;
#(
  parameter int WIDTH = 25
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  // Status
  output logic                  done
);
  initial
  begin
    if (WIDTH < 5 || WIDTH > 31)
      $error("cssc_delay_counter: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] remain;
  } cssc_cnt_t;

  cssc_cnt_t cnt_q;
  cssc_cnt_t cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (load)
      cnt_d.remain = count;
    else if (cnt_q.remain != '0)
      cnt_d.remain = cnt_q.remain - WIDTH'(1);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign done = !load && (cnt_q.remain == '0);
endmodule

// ---- cssc_clock_start_and_sleep_ctrl.sv ----
// Functional notes
// R1 - Internal RC: start codes 00/01/10 give 6 cycles plus 0, 4.1ms, 65ms
// R2 - Every chip reset loads the factory calibration byte into osc_trim
// R3 - Trim zero is slowest, larger values faster, FF fastest
// R4 - Trim 00, 7F, FF span 50-100, 75-150, 100-200 percent
// R5 - Software keeps trim within ten percent over nominal during memory writes
// R6 - External clock is used only with clock origin code 0000
// R7 - External clock: start codes 00/01/10 give 6 cycles plus 0, 4.1ms, 65ms
// R8 - External clock steps above two percent only while held in reset
// R9 - Sleep entered only with sleep arm bit set and sleep instruction
// R10 - Sleep kind at bits 7,5,4; codes 100 and 101 reserved
// R11 - Standby kinds only with crystal or resonator selected
// R12 - Interrupt wake halts four cycles beyond start-up, then resumes
// R13 - Register file and SRAM kept unchanged across sleep
// R14 - Reset during sleep wakes and restarts at the reset vector
// R15 - Idle stops cpu and flash clocks only
// R16 - Power-down stops oscillator and all generated clocks
// R17 - Power-save keeps only the asynchronous timer clock
// R18 - Standby keeps oscillator and wakes within six cycles
// R19 - Sleep with a reserved kind code acts as no-operation
// R20 - All bits of osc_trim and power_control read and write anytime; a write in the ST_RESET cycle after reset is overwritten
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
module cssc_clock_start_and_sleep_ctrl
  import cssc_pkg::*;
#(
  parameter int DLY1_CYC = CSSC_DLY1_CYC,
  parameter int DLY2_CYC = CSSC_DLY2_CYC
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Fuses and factory byte
  input  wire logic [3:0]  clockOriginCode,
  input  wire logic [1:0]  startDelayCode,
  input  wire logic [7:0]  factoryTrim,
  // Core side
  input  wire logic        sleepInstr,
  input  wire logic        wakeIrq,
  output logic             coreHalt,
  output logic             resetVectorStart,
  output logic             sleepNop,
  // Clock tree
  output logic [7:0]       trimValue,
  output logic             useExtClock,
  output cssc_gates_t      clockGates
);
  initial
  begin
    if (DLY1_CYC < 1 || DLY2_CYC < DLY1_CYC || DLY2_CYC > 2**25 - 1)
      $error("cssc_clock_start_and_sleep_ctrl: delay counts out of range");
  end

  typedef struct packed {
    cssc_state_t state;
    logic [7:0]  trim;
    logic [7:0]  pctrl;
    logic [2:0]  kind;
    logic [2:0]  step;
    logic        fromReset;
    logic        nop;
    logic        load;
    logic [24:0] loadVal;
    logic [31:0] rdata;
  } cssc_regs_t;

  cssc_regs_t r_q;
  cssc_regs_t r_d;
  logic       cntDone;
  logic [2:0] kindNow;
  logic       xtalSel;
  logic       kindOk;
  logic       access;

  cssc_delay_counter #(
    .WIDTH (25)
  ) u_delay (
    .clk   (clk),
    .reset (reset),
    .load  (r_q.load),
    .count (r_q.loadVal),
    .done  (cntDone)
  );

  assign kindNow = {r_q.pctrl[CSSC_KIND_HI], r_q.pctrl[CSSC_KIND_MID], r_q.pctrl[CSSC_KIND_LO]};
  // Crystal or resonator origins
  assign xtalSel = clockOriginCode >= CSSC_ORIGIN_XTAL;
  always_comb
  begin
    unique case (kindNow)
      KIND_RES4, KIND_RES5: kindOk = 1'b0;                 // [R10] [R19]
      KIND_STBY, KIND_XSTBY: kindOk = xtalSel;             // [R11]
      default: kindOk = 1'b1;
    endcase
  end
  assign access = psel && penable;

  always_comb
  begin
    r_d = r_q;
    r_d.load = 1'b0;
    r_d.nop = 1'b0;
    // Register writes and reads
    if (access && pwrite && pstrb[0])
    begin
      if (paddr == CSSC_OFF_TRIM)
        r_d.trim = pwdata[7:0];                            // [R20] [R3]
      if (paddr == CSSC_OFF_PCTRL)
        r_d.pctrl = pwdata[7:0];                           // [R20]
    end
    // Read data captured in setup so it stands through the access cycle
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        CSSC_OFF_TRIM:   r_d.rdata = {24'h000000, r_q.trim};
        CSSC_OFF_PCTRL:  r_d.rdata = {24'h000000, r_q.pctrl};
        CSSC_OFF_STATUS: r_d.rdata = {26'h0, r_q.nop, r_q.fromReset, 1'b0, r_q.kind};
        default:         r_d.rdata = 32'h00000000;
      endcase
    end
    unique case (r_q.state)
      ST_RESET:
      begin
        r_d.trim = factoryTrim;                            // [R2]
        r_d.pctrl = CSSC_PCTRL_RST;
        r_d.fromReset = 1'b1;                              // [R14]
        r_d.load = 1'b1;
        r_d.state = ST_START;
        unique case (startDelayCode)                       // [R1] [R7]
          2'h1: r_d.loadVal = 25'(DLY1_CYC + CSSC_START_CK);
          2'h2: r_d.loadVal = 25'(DLY2_CYC + CSSC_START_CK);
          default: r_d.loadVal = 25'(CSSC_START_CK);
        endcase
      end
      ST_RUN:
      begin
        r_d.fromReset = 1'b0;
        if (sleepInstr && r_q.pctrl[CSSC_ARM_BIT])         // [R9]
        begin
          if (kindOk)
          begin
            r_d.kind = kindNow;
            r_d.state = ST_SLEEP;
          end
          else
            r_d.nop = 1'b1;                                // [R19]
        end
      end
      ST_SLEEP:
        if (wakeIrq)
        begin
          r_d.load = 1'b1;
          r_d.state = ST_START;
          // Load and done latency already spends two start cycles
          if (r_q.kind == KIND_STBY || r_q.kind == KIND_XSTBY)
            r_d.loadVal = 25'(CSSC_STBY_CK - CSSC_WAKE_HALT - CSSC_LOAD_LAG); // [R18]
          else
            r_d.loadVal = 25'(CSSC_START_CK - CSSC_LOAD_LAG);               // [R12]
        end
      ST_START:
        if (cntDone)
        begin
          r_d.step = 3'h0;
          r_d.state = r_q.fromReset ? ST_RUN : ST_HALT;
        end
      ST_HALT:
      begin
        r_d.step = r_q.step + 3'h1;
        if (r_q.step == 3'(CSSC_WAKE_HALT - 1))            // [R12]
          r_d.state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r_q <= '0;
      r_q.state <= ST_RESET;                               // [R14] [R2]
    end
    else
      r_q <= r_d;
  end

  // APB answers in the access cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = r_q.rdata;
  assign trimValue = r_q.trim;                             // [R4]
  assign useExtClock = clockOriginCode == CSSC_ORIGIN_EXT; // [R6]
  assign coreHalt = r_q.state != ST_RUN;                   // [R13]
  assign resetVectorStart = r_q.state == ST_START && r_q.fromReset;
  assign sleepNop = r_q.nop;

  always_comb
  begin
    clockGates = '1;
    if (r_q.state == ST_SLEEP)
    begin
      clockGates.cpu = 1'b0;                               // [R15]
      clockGates.flash = 1'b0;
      unique case (r_q.kind)
        KIND_IDLE: ;
        KIND_NOISE: clockGates.io = 1'b0;
        KIND_PDOWN: clockGates = '0;                       // [R16]
        KIND_PSAVE: clockGates = '{default: 1'b0, asy: 1'b1}; // [R17]
        KIND_STBY: clockGates = '{default: 1'b0, mainOsc: 1'b1}; // [R18]
        default: clockGates = '{default: 1'b0, asy: 1'b1, mainOsc: 1'b1};
      endcase
    end
    else if (r_q.state == ST_START && !r_q.fromReset)
      clockGates.cpu = 1'b0;
  end

  sequence wakeSeen;
    r_q.state == ST_SLEEP && wakeIrq;
  endsequence

  sequence slowWake;
    r_q.state == ST_SLEEP && wakeIrq && !r_q.kind[2];
  endsequence

  sequence trimWrite;
    access && pwrite && pstrb[0] && paddr == CSSC_OFF_TRIM && r_q.state != ST_RESET;
  endsequence

  sequence pctrlWrite;
    access && pwrite && pstrb[0] && paddr == CSSC_OFF_PCTRL && r_q.state != ST_RESET;
  endsequence

  sequence haltLast;
    r_q.state == ST_HALT && r_q.step == 3'h3;
  endsequence

  wake_halt_a: assert property (@(posedge clk) disable iff (reset) // [R12]
    slowWake |-> ##1 coreHalt [*8] ##1 coreHalt ##1 coreHalt ##1 !coreHalt)
    else $error("wake halt length wrong");
  stby_wake_a: assert property (@(posedge clk) disable iff (reset) // [R18]
    wakeSeen and r_q.kind[2] |-> ##[1:7] !coreHalt)
    else $error("standby wake too slow");
  halt_done_a: assert property (@(posedge clk) disable iff (reset) // [R12]
    haltLast |=> r_q.state == ST_RUN)
    else $error("halt not ended");
  halt_entry_a: assert property (@(posedge clk) disable iff (reset) // [R12]
    $rose(r_q.state == ST_HALT) |-> r_q.step == 3'h0)
    else $error("halt count not cleared");
  wake_vector_a: assert property (@(posedge clk) disable iff (reset) // [R12]
    wakeSeen |=> !resetVectorStart)
    else $error("wake went to reset vector");
  reset_vector_a: assert property (@(posedge clk) // [R14]
    $fell(reset) |=> resetVectorStart && coreHalt)
    else $error("reset vector start missing");
  trim_write_a: assert property (@(posedge clk) disable iff (reset) // [R20]
    trimWrite |=> trimValue == $past(pwdata[7:0]))
    else $error("trim write lost");
  pctrl_write_a: assert property (@(posedge clk) disable iff (reset) // [R20]
    pctrlWrite |=> r_q.pctrl == $past(pwdata[7:0]))
    else $error("power control write lost");
  trim_read_a: assert property (@(posedge clk) disable iff (reset) // [R20]
    psel && !penable && !pwrite && paddr == CSSC_OFF_TRIM
    |=> prdata == {24'h000000, $past(trimValue)})
    else $error("trim read wrong");
  run_gates_a: assert property (@(posedge clk) disable iff (reset) // [R15]
    r_q.state == ST_RUN |-> clockGates == 6'h3F)
    else $error("run gating wrong");
  noise_gate_a: assert property (@(posedge clk) disable iff (reset) // [R10]
    r_q.state == ST_SLEEP && r_q.kind == KIND_NOISE |-> clockGates == 6'h07)
    else $error("noise gating wrong");
  psave_gate_a: assert property (@(posedge clk) disable iff (reset) // [R17]
    r_q.state == ST_SLEEP && r_q.kind == KIND_PSAVE |-> clockGates == 6'h02)
    else $error("power-save gating wrong");
  stby_gate_a: assert property (@(posedge clk) disable iff (reset) // [R18]
    r_q.state == ST_SLEEP && r_q.kind == KIND_STBY |-> clockGates == 6'h01)
    else $error("standby gating wrong");
  xstby_gate_a: assert property (@(posedge clk) disable iff (reset) // [R18]
    r_q.state == ST_SLEEP && r_q.kind == KIND_XSTBY |-> clockGates == 6'h03)
    else $error("extended standby gating wrong");
  nop_run_a: assert property (@(posedge clk) disable iff (reset) // [R19]
    sleepNop |-> r_q.state == ST_RUN)
    else $error("ignored sleep stopped core");
  arm_sleep_a: assert property (@(posedge clk) disable iff (reset) // [R9]
    $rose(r_q.state == ST_SLEEP) |-> $past(r_q.pctrl[CSSC_ARM_BIT]) && $past(sleepInstr))
    else $error("sleep without arm");
  res_nop_a: assert property (@(posedge clk) disable iff (reset) // [R19]
    r_q.state == ST_RUN && sleepInstr && r_q.pctrl[CSSC_ARM_BIT] && kindNow[2:1] == 2'b10
    |=> r_q.state == ST_RUN && sleepNop)
    else $error("reserved kind slept");
  trim_load_a: assert property (@(posedge clk) // [R2]
    $fell(reset) |=> trimValue == $past(factoryTrim))
    else $error("trim not loaded");
  stby_xtal_a: assert property (@(posedge clk) disable iff (reset) // [R11]
    r_q.state == ST_SLEEP && r_q.kind[2] |-> xtalSel)
    else $error("standby without crystal");
  idle_gate_a: assert property (@(posedge clk) disable iff (reset) // [R15]
    r_q.state == ST_SLEEP && r_q.kind == KIND_IDLE |-> !clockGates.cpu && clockGates.io)
    else $error("idle gating wrong");
  pdown_gate_a: assert property (@(posedge clk) disable iff (reset) // [R16]
    r_q.state == ST_SLEEP && r_q.kind == KIND_PDOWN |-> clockGates == '0)
    else $error("power-down gating wrong");
  reset_start_a: assert property (@(posedge clk) // [R1]
    $fell(reset) && startDelayCode == 2'h0 |=> coreHalt [*8] ##1 !coreHalt)
    else $error("start delay wrong");
endmodule

// ---- clock_start_and_sleep_ctrl_bench.sv ----
`timescale 1ns/1ns
module clock_start_and_sleep_ctrl_bench
  import cssc_pkg::*;
;
  localparam int D1 = 20;
  localparam int D2 = 40;
  localparam int WAKE_N = 1 + CSSC_START_CK + CSSC_WAKE_HALT;
  localparam int STBY_N = 1 + CSSC_STBY_CK;
  // Clock and reset
  logic        clk;
  logic        reset;
  // APB
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // Fuses and core side
  logic [3:0]  clockOriginCode;
  logic [1:0]  startDelayCode;
  logic [7:0]  factoryTrim;
  logic        sleepInstr;
  logic        wakeIrq;
  logic        coreHalt;
  logic        resetVectorStart;
  logic        sleepNop;
  logic [7:0]  trimValue;
  logic        useExtClock;
  cssc_gates_t clockGates;
  int          mismatches;
  int          check_count;
  logic [31:0] rd;
  int          n;

  cssc_clock_start_and_sleep_ctrl #(.DLY1_CYC(D1), .DLY2_CYC(D2)) u_cssc_clock_start_and_sleep_ctrl (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clockOriginCode(clockOriginCode), .startDelayCode(startDelayCode),
    .factoryTrim(factoryTrim), .sleepInstr(sleepInstr), .wakeIrq(wakeIrq),
    .coreHalt(coreHalt), .resetVectorStart(resetVectorStart), .sleepNop(sleepNop),
    .trimValue(trimValue), .useExtClock(useExtClock), .clockGates(clockGates)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 50)
    begin
      mismatches++;
      wrap_up();
    end
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
    #1;
  endtask

  task automatic wait_run(output int cnt);
    for (cnt = 1; cnt < 200; cnt++)
    begin
      @(posedge clk);
      #1 if (coreHalt === 1'b0) return;
    end
    mismatches++;
    wrap_up();
  endtask

  task automatic do_reset(input logic [1:0] code, input logic [3:0] org, input int expN);
    @(posedge clk);
    reset <= 1'b1; startDelayCode <= code; clockOriginCode <= org;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 check(resetVectorStart, 1'b1);
    check(trimValue, factoryTrim);
    check(useExtClock, org == 4'h0);
    wait_run(n);
    check(n, expN);
    $display("test reset code %0d done", code);
  endtask

  task automatic sleep_try(input logic [2:0] k, input logic arm, input logic [5:0] g, input int w);
    apb(1'b1, CSSC_OFF_PCTRL, {24'h0, k[2], arm, k[1:0], 4'h0});
    apb(1'b0, CSSC_OFF_PCTRL, 32'h0);
    check(rd, {24'h0, k[2], arm, k[1:0], 4'h0});
    @(posedge clk);
    sleepInstr <= 1'b1;
    @(posedge clk);
    sleepInstr <= 1'b0;
    #1 check(coreHalt, w != 0);
    check(sleepNop, arm && w == 0);
    if (w != 0)
    begin
      check(clockGates, g);
      @(posedge clk);
      wakeIrq <= 1'b1;
      wait_run(n);
      @(posedge clk);
      wakeIrq <= 1'b0;
      check(n, w);
    end
    $display("test sleep kind %0d arm %0d done", k, arm);
  endtask

  task automatic reg_test();
    logic [7:0] v [3] = '{8'h00, 8'h7F, 8'hFF};
    apb(1'b0, CSSC_OFF_PCTRL, 32'h0);
    check(rd, CSSC_PCTRL_RST);
    foreach (v[i])
    begin
      apb(1'b1, CSSC_OFF_TRIM, {24'h0, v[i]});
      check(trimValue, v[i]);
      apb(1'b0, CSSC_OFF_TRIM, 32'h0);
      check(rd, {24'h0, v[i]});
    end
    apb(1'b1, CSSC_OFF_PCTRL, 32'h0000008F);
    apb(1'b0, CSSC_OFF_PCTRL, 32'h0);
    check(rd, 32'h8F);
    apb(1'b1, 12'h00C, 32'h55);
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, 32'h0);
    $display("test registers done");
  endtask

  initial
  begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'hF; clockOriginCode = 4'h1; startDelayCode = 2'h0;
    factoryTrim = 8'h5A; sleepInstr = 1'b0; wakeIrq = 1'b0;
    mismatches = 0; check_count = 0;
    do_reset(2'h0, 4'h1, 8);
    @(posedge clk);
    factoryTrim <= 8'hC3;
    do_reset(2'h1, 4'h0, 8 + D1);
    do_reset(2'h2, 4'h4, 8 + D2);
    reg_test();
    sleep_try(KIND_IDLE, 1'b0, 6'h00, 0);
    sleep_try(KIND_IDLE, 1'b1, 6'h0F, WAKE_N);
    sleep_try(KIND_NOISE, 1'b1, 6'h07, WAKE_N);
    sleep_try(KIND_PDOWN, 1'b1, 6'h00, WAKE_N);
    sleep_try(KIND_PSAVE, 1'b1, 6'h02, WAKE_N);
    sleep_try(KIND_RES4, 1'b1, 6'h00, 0);
    sleep_try(KIND_RES5, 1'b1, 6'h00, 0);
    sleep_try(KIND_STBY, 1'b1, 6'h00, 0);
    do_reset(2'h0, CSSC_ORIGIN_XTAL, 8);
    sleep_try(KIND_STBY, 1'b1, 6'h01, STBY_N);
    sleep_try(KIND_XSTBY, 1'b1, 6'h03, STBY_N);
    apb(1'b1, CSSC_OFF_PCTRL, 32'h00000060);
    @(posedge clk);
    sleepInstr <= 1'b1;
    @(posedge clk);
    sleepInstr <= 1'b0;
    do_reset(2'h0, 4'h1, 8);
    wrap_up();
  end
endmodule
